// ===== src/rfsc_host.sv
// Controller end: checks software orders and drives the device register bus.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module rfsc_host (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Register bus to the device
  rfsc_if.host bus,
  // Software port
  input wire logic [3:0] sw_addr_in,
  input wire logic [19:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [19:0] sw_rdata_out,
  // Interrupt
  output logic irq_out
);

  typedef enum logic [2:0] {
    RFSC_ST_IDLE = 3'b000,
    RFSC_ST_SEND_HI = 3'b001,
    RFSC_ST_FINISH = 3'b010,
    RFSC_ST_RD_WAIT = 3'b011,
    RFSC_ST_CAPTURE = 3'b100
  } rfsc_state_t;

  rfsc_state_t state;
  logic [15:0] hi_word;
  logic [7:0] addr_q;
  logic [15:0] wdata_q;
  logic wr_q;
  logic rd_q;
  logic [1:0] lock_val;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic [19:0] rdata_q;
  logic cmd;
  logic cmd_ok;
  logic idle;
  logic [15:0] lo_word;
  logic [15:0] hi_next;
  logic [7:0] addr_next;
  logic two_part;
  logic is_read;
  logic [12:0] r_val;

  assign idle = (state == RFSC_ST_IDLE);
  assign cmd = sw_wr_in && (sw_addr_in <= rfsc_pkg::HREG_LOCK_REQ);
  assign r_val = sw_wdata_in[12:0];

  // ----------------------------------------
  // Order checking
  // ----------------------------------------
  always_comb begin
    cmd_ok = idle;
    lo_word = 16'h0000;
    hi_next = 16'h0000;
    addr_next = rfsc_pkg::DIVLOAD_ADDR;
    two_part = 1'b1;
    is_read = 1'b0;
    if (sw_addr_in == rfsc_pkg::HREG_CTRL) begin
      addr_next = rfsc_pkg::CTRL_ADDR;
      two_part = 1'b0;
      lo_word = sw_wdata_in[15:0];
      lo_word[rfsc_pkg::FIXED_ZERO_BIT] = 1'b0;
      if (sw_wdata_in[10:9] == rfsc_pkg::RFSC_EN_BAD) begin
        cmd_ok = 1'b0;
      end else if (sw_wdata_in[2:1] == rfsc_pkg::RFSC_EN_BAD) begin
        cmd_ok = 1'b0;
      end
    end else if (sw_addr_in == rfsc_pkg::HREG_RX_N) begin
      if (sw_wdata_in < rfsc_pkg::N_MIN || sw_wdata_in > rfsc_pkg::N_MAX) begin
        cmd_ok = 1'b0;
      end
      lo_word = {1'b0, rfsc_pkg::SEL_RX_N_LO, sw_wdata_in[9:0]};
      hi_next = {1'b0, rfsc_pkg::SEL_RX_N_HI, sw_wdata_in[19:10]};
    end else if (sw_addr_in == rfsc_pkg::HREG_RX_R || sw_addr_in == rfsc_pkg::HREG_TX_R) begin
      if (sw_wdata_in[19:13] != 7'h00 || r_val < rfsc_pkg::R_MIN || r_val > rfsc_pkg::R_MAX) begin
        cmd_ok = 1'b0;
      end
      if (sw_addr_in == rfsc_pkg::HREG_RX_R) begin
        lo_word = {1'b0, rfsc_pkg::SEL_RX_R_LO, r_val[9:0]};
        hi_next = {1'b0, rfsc_pkg::SEL_RX_R_HI, 7'h00, r_val[12:10]};
      end else begin
        lo_word = {1'b0, rfsc_pkg::SEL_TX_R_LO, r_val[9:0]};
        hi_next = {1'b0, rfsc_pkg::SEL_TX_R_HI, 7'h00, r_val[12:10]};
      end
    end else begin
      addr_next = rfsc_pkg::LOCK_ADDR;
      two_part = 1'b0;
      is_read = 1'b1;
    end
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= RFSC_ST_IDLE;
      addr_q <= 8'h00;
      wdata_q <= 16'h0000;
      hi_word <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state)
        RFSC_ST_IDLE: begin
          if (cmd && cmd_ok) begin
            addr_q <= addr_next;
            wdata_q <= lo_word;
            hi_word <= hi_next;
            wr_q <= !is_read;
            rd_q <= is_read;
            if (is_read) begin
              state <= RFSC_ST_RD_WAIT;
            end else if (two_part) begin
              state <= RFSC_ST_SEND_HI;
            end else begin
              state <= RFSC_ST_FINISH;
            end
          end
        end
        RFSC_ST_SEND_HI: begin
          wr_q <= 1'b1;
          wdata_q <= hi_word;
          state <= RFSC_ST_FINISH;
        end
        RFSC_ST_RD_WAIT: begin
          state <= RFSC_ST_CAPTURE;
        end
        default: begin
          state <= RFSC_ST_IDLE;
        end
      endcase
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lock_val <= 2'h0;
    end else if (state == RFSC_ST_CAPTURE) begin
      lock_val <= bus.rdata[1:0];
    end
  end

  // ----------------------------------------
  // Interrupts and software reads
  // ----------------------------------------
  always_comb begin
    irq_set = 3'h0;
    irq_set[rfsc_pkg::IRQ_DONE_BIT] = (state == RFSC_ST_FINISH) || (state == RFSC_ST_CAPTURE);
    irq_set[rfsc_pkg::IRQ_REFUSED_BIT] = cmd && !cmd_ok;
    irq_set[rfsc_pkg::IRQ_LOCK_BIT] = (state == RFSC_ST_CAPTURE) && (bus.rdata[1:0] != lock_val);
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_status <= rfsc_pkg::IRQ_RESET;
    end else if (sw_rd_in && sw_addr_in == rfsc_pkg::HREG_IRQ_STATUS) begin
      irq_status <= irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_mask <= rfsc_pkg::IRQ_RESET;
    end else if (sw_wr_in && sw_addr_in == rfsc_pkg::HREG_IRQ_MASK) begin
      irq_mask <= sw_wdata_in[2:0];
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 20'h00000;
    end else if (!sw_rd_in) begin
      rdata_q <= 20'h00000;
    end else if (sw_addr_in == rfsc_pkg::HREG_LOCK) begin
      rdata_q <= {18'h00000, lock_val};
    end else if (sw_addr_in == rfsc_pkg::HREG_IRQ_STATUS) begin
      rdata_q <= {17'h00000, irq_status};
    end else if (sw_addr_in == rfsc_pkg::HREG_IRQ_MASK) begin
      rdata_q <= {17'h00000, irq_mask};
    end else if (sw_addr_in == rfsc_pkg::HREG_BUSY) begin
      rdata_q <= {19'h00000, !idle};
    end else begin
      rdata_q <= 20'h00000;
    end
  end

  assign sw_rdata_out = rdata_q;

endmodule

// ===== inc/rfsc_pkg.sv
// Shared constants for the synthesiser control and status ends.
package rfsc_pkg;
  // ----------------------------------------
  // Device register bus
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] DIVLOAD_ADDR = 8'hB2;
  localparam logic [7:0] CTRL_ADDR = 8'hB3;
  localparam logic [7:0] LOCK_ADDR = 8'hB4;
  localparam logic [7:0] MAIN_STATUS_ADDR = 8'h7E;
  // ----------------------------------------
  // Divider load word layout
  // ----------------------------------------
  localparam int LOAD_RSVD_BIT = 15;
  localparam int LOAD_SEL_MSB = 14;
  localparam int LOAD_SEL_LSB = 10;
  localparam logic [4:0] SEL_TX_R_LO = 5'h1A;
  localparam logic [4:0] SEL_TX_R_HI = 5'h1B;
  localparam logic [4:0] SEL_RX_N_LO = 5'h1C;
  localparam logic [4:0] SEL_RX_N_HI = 5'h1D;
  localparam logic [4:0] SEL_RX_R_LO = 5'h1E;
  localparam logic [4:0] SEL_RX_R_HI = 5'h1F;
  localparam logic [19:0] N_MIN = 20'h00440;
  localparam logic [19:0] N_MAX = 20'hFFFFF;
  localparam logic [12:0] R_MIN = 13'h0002;
  localparam logic [12:0] R_MAX = 13'h1FFF;
  localparam logic [19:0] N_RESET = 20'h00000;
  localparam logic [12:0] R_RESET = 13'h0000;
  // ----------------------------------------
  // Control word layout
  // ----------------------------------------
  localparam int REF_SEL_BIT = 15;
  localparam int SYNTH_STRIDE = 8;
  localparam int PS_BIT = 0;
  localparam int TX_BIT = 1;
  localparam int RX_BIT = 2;
  localparam int GAIN_BIT = 3;
  localparam int SIGN_BIT = 4;
  localparam int TOL_BIT = 5;
  localparam int TEST_BIT = 6;
  localparam int FIXED_ZERO_BIT = 7;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int LOCK_CHANGE_BIT = 1;
  typedef enum logic [1:0] {
    RFSC_EN_OFF = 2'b00,
    RFSC_EN_TX = 2'b01,
    RFSC_EN_RX = 2'b10,
    RFSC_EN_BAD = 2'b11
  } rfsc_en_t;
  // ----------------------------------------
  // Controller software registers
  // ----------------------------------------
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_RX_N = 4'h1;
  localparam logic [3:0] HREG_RX_R = 4'h2;
  localparam logic [3:0] HREG_TX_R = 4'h3;
  localparam logic [3:0] HREG_LOCK_REQ = 4'h4;
  localparam logic [3:0] HREG_LOCK = 4'h5;
  localparam logic [3:0] HREG_IRQ_STATUS = 4'h6;
  localparam logic [3:0] HREG_IRQ_MASK = 4'h7;
  localparam logic [3:0] HREG_BUSY = 4'h8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_LOCK_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage

// ===== inc/rfsc_if.sv
// Register bus joining the controller end and the device end.
`timescale 1ns/1ns
interface rfsc_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata
  );
  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata
  );
endinterface

// ===== src/rfsc_device.sv
// Device end: synthesiser control word, divider loading and lock status.
`timescale 1ns/1ns
// Contract
// - Host keeps N divider within 1088..1048575.
// - Host keeps R divider within 2..8191.
// - Host writes divider load bit 15 as zero.
// - Receive R loads as low ten, high three.
// - Bit 15 picks crystal or synth clock.
// - Bits 14 and 6 enable test mode.
// - Bits 13 and 5 choose lock tolerance.
// - Bits 12 and 4 set pump polarity.
// - Bits 11 and 3 set pump gain.
// - Enable field: off, transmit, receive, never 11.
// - Bits 8 and 0 are active-low power-save.
// - Lock status: bit1 synth2, bit0 synth1.
// - Lock change sets main status bit 1.
// - Reading lock status clears that flag.
// - Transmit R and receive N also loadable.
module rfsc_device (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Register bus
  rfsc_if.dev bus,
  // Lock indications from the loops, index 0 is synthesiser 1
  input wire logic [1:0] lock_in,
  // Shared reference selection
  output logic ref_sel_crystal_out,
  // Per-synthesiser settings, index 0 is synthesiser 1
  output logic [1:0] test_mode_out,
  output logic [1:0] lock_tol4_out,
  output logic [1:0] cp_negative_out,
  output logic [1:0] cp_high_gain_out,
  output logic [1:0] tx_enable_out,
  output logic [1:0] rx_enable_out,
  output logic [1:0] power_save_active_low_out,
  // Divider values
  output logic [19:0] rx_n_div_out,
  output logic [12:0] rx_r_div_out,
  output logic [12:0] tx_r_div_out,
  // Status
  output logic lock_change_out
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] ctrl_word;
  logic [19:0] rx_n_div;
  logic [12:0] rx_r_div;
  logic [12:0] tx_r_div;
  logic [1:0] lock_meta;
  logic [1:0] lock_sync;
  logic [1:0] lock_prev;
  logic lock_change;
  logic [15:0] rdata_q;
  logic ctrl_wr;
  logic load_wr;
  logic lock_rd;
  logic lock_event;
  logic [4:0] load_sel;
  logic [9:0] load_data;
  logic [7:0] lock_status;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign ctrl_wr = bus.wr && (bus.addr == rfsc_pkg::CTRL_ADDR);
  assign load_wr = bus.wr && (bus.addr == rfsc_pkg::DIVLOAD_ADDR);
  assign lock_rd = bus.rd && (bus.addr == rfsc_pkg::LOCK_ADDR);
  assign load_sel = bus.wdata[rfsc_pkg::LOAD_SEL_MSB:rfsc_pkg::LOAD_SEL_LSB];
  assign load_data = bus.wdata[9:0];

  // ----------------------------------------
  // Control word
  // ----------------------------------------
  // bit stored inert.
  // The fixed-zero position is kept but drives nothing.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_word <= rfsc_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_word <= bus.wdata;
    end
  end

  assign ref_sel_crystal_out = ctrl_word[rfsc_pkg::REF_SEL_BIT];

  // ----------------------------------------
  // Per-synthesiser settings
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_synth
    localparam int B = i * rfsc_pkg::SYNTH_STRIDE;
    logic [1:0] en_code;
    assign en_code = {ctrl_word[B + rfsc_pkg::RX_BIT], ctrl_word[B + rfsc_pkg::TX_BIT]};
    assign test_mode_out[i] = ctrl_word[B + rfsc_pkg::TEST_BIT];
    assign lock_tol4_out[i] = ctrl_word[B + rfsc_pkg::TOL_BIT];
    assign cp_negative_out[i] = ctrl_word[B + rfsc_pkg::SIGN_BIT];
    assign cp_high_gain_out[i] = ctrl_word[B + rfsc_pkg::GAIN_BIT];
    assign tx_enable_out[i] = (en_code == rfsc_pkg::RFSC_EN_TX);
    assign rx_enable_out[i] = (en_code == rfsc_pkg::RFSC_EN_RX);
    assign power_save_active_low_out[i] = ctrl_word[B + rfsc_pkg::PS_BIT];
  end

  // ----------------------------------------
  // Divider loading
  // ----------------------------------------
  // receive reference in two parts.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_r_div <= rfsc_pkg::R_RESET;
    end else if (load_wr && load_sel == rfsc_pkg::SEL_RX_R_LO) begin
      rx_r_div[9:0] <= load_data;
    end else if (load_wr && load_sel == rfsc_pkg::SEL_RX_R_HI) begin
      rx_r_div[12:10] <= bus.wdata[2:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_r_div <= rfsc_pkg::R_RESET;
    end else if (load_wr && load_sel == rfsc_pkg::SEL_TX_R_LO) begin
      tx_r_div[9:0] <= load_data;
    end else if (load_wr && load_sel == rfsc_pkg::SEL_TX_R_HI) begin
      tx_r_div[12:10] <= bus.wdata[2:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_n_div <= rfsc_pkg::N_RESET;
    end else if (load_wr && load_sel == rfsc_pkg::SEL_RX_N_LO) begin
      rx_n_div[9:0] <= load_data;
    end else if (load_wr && load_sel == rfsc_pkg::SEL_RX_N_HI) begin
      rx_n_div[19:10] <= load_data;
    end
  end

  assign rx_n_div_out = rx_n_div;
  assign rx_r_div_out = rx_r_div;
  assign tx_r_div_out = tx_r_div;

  // ----------------------------------------
  // Lock indication capture
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lock_meta <= 2'h0;
      lock_sync <= 2'h0;
      lock_prev <= 2'h0;
    end else begin
      lock_meta <= lock_in;
      lock_sync <= lock_meta;
      lock_prev <= lock_sync;
    end
  end

  assign lock_status = {6'h00, lock_sync};

  // ----------------------------------------
  // Lock change flag
  // ----------------------------------------
  // detect any lock change.
  assign lock_event = (lock_sync != lock_prev);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lock_change <= 1'b0;
    end else if (lock_event) begin
      lock_change <= 1'b1;
    end else if (lock_rd) begin
      lock_change <= 1'b0;
    end
  end

  assign lock_change_out = lock_change;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 16'h0000;
    end else if (!bus.rd) begin
      rdata_q <= 16'h0000;
    end else if (bus.addr == rfsc_pkg::LOCK_ADDR) begin
      rdata_q <= {8'h00, lock_status};
    end else if (bus.addr == rfsc_pkg::MAIN_STATUS_ADDR) begin
      rdata_q <= 16'h0000;
      rdata_q[rfsc_pkg::LOCK_CHANGE_BIT] <= lock_change;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign bus.rdata = rdata_q;

endmodule

// ===== test/rfsc_assertions.sv
// Concurrent checks on the register bus joining the two ends.
`timescale 1ns/1ns
module rfsc_assertions (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Bus signals
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic load;
  logic ctrl_wr;
  assign load = wr && (addr == rfsc_pkg::DIVLOAD_ADDR);
  assign ctrl_wr = wr && (addr == rfsc_pkg::CTRL_ADDR);
  sequence s_piece(logic [4:0] code);
    load && (wdata[14:10] == code);
  endsequence
  sequence s_lock_rd;
    rd && (addr == rfsc_pkg::LOCK_ADDR);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_load_rsvd_zero: assert property (load |-> !wdata[15])
    else $error("Divider load reserved bit set");
  a_ctrl_bit7_zero: assert property (ctrl_wr |-> !wdata[7])
    else $error("Control word bit 7 set");
  a_enable_not_both: assert property (ctrl_wr |->
    (wdata[10:9] != 2'h3) && (wdata[2:1] != 2'h3))
    else $error("Enable code 11 written");
  a_n_high_nonzero: assert property (s_piece(rfsc_pkg::SEL_RX_N_HI) |->
    (wdata[9:0] != 10'h000))
    else $error("Feedback divider below range");
  a_r_high_range: assert property (load && (wdata[14:10] == rfsc_pkg::SEL_RX_R_HI ||
    wdata[14:10] == rfsc_pkg::SEL_TX_R_HI) |-> (wdata[9:3] == 7'h00))
    else $error("Reference divider above range");
  a_rx_r_pair: assert property (s_piece(rfsc_pkg::SEL_RX_R_LO) |=>
    s_piece(rfsc_pkg::SEL_RX_R_HI))
    else $error("Receive reference high piece missing");
  a_n_pair: assert property (s_piece(rfsc_pkg::SEL_RX_N_LO) |=>
    s_piece(rfsc_pkg::SEL_RX_N_HI))
    else $error("Feedback divider high piece missing");
  a_lock_upper_zero: assert property (s_lock_rd |=>
    (rdata[15:2] == 14'h0000))
    else $error("Lock status upper bits not zero");
endmodule

// ===== test/tb_rf_synth_control_status.sv
// Self-checking bench joining the controller end and the device end.
`timescale 1ns/1ns
module tb_rf_synth_control_status;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] lock_in = 2'h0;
  logic [3:0] sw_addr_in = 4'h0;
  logic [19:0] sw_wdata_in = 20'h00000;
  logic sw_wr_in = 1'b0;
  logic sw_rd_in = 1'b0;
  logic [19:0] sw_rdata_out;
  logic irq_out, ref_sel_crystal_out, lock_change_out;
  logic [1:0] test_mode_out, lock_tol4_out, cp_negative_out, cp_high_gain_out;
  logic [1:0] tx_enable_out, rx_enable_out, power_save_active_low_out;
  logic [19:0] rx_n_div_out;
  logic [12:0] rx_r_div_out, tx_r_div_out;
  int n_mismatch = 0;
  int compares = 0;
  rfsc_if rfsc_if_i ();
  rfsc_device rfsc_device_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .bus(rfsc_if_i.dev), .lock_in(lock_in), .ref_sel_crystal_out(ref_sel_crystal_out),
    .test_mode_out(test_mode_out), .lock_tol4_out(lock_tol4_out),
    .cp_negative_out(cp_negative_out), .cp_high_gain_out(cp_high_gain_out),
    .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
    .power_save_active_low_out(power_save_active_low_out), .rx_n_div_out(rx_n_div_out),
    .rx_r_div_out(rx_r_div_out), .tx_r_div_out(tx_r_div_out),
    .lock_change_out(lock_change_out));
  rfsc_host rfsc_host_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .bus(rfsc_if_i.host), .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
    .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
    .irq_out(irq_out));
  rfsc_assertions rfsc_assertions_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .addr(rfsc_if_i.addr), .wdata(rfsc_if_i.wdata), .wr(rfsc_if_i.wr),
    .rd(rfsc_if_i.rd), .rdata(rfsc_if_i.rdata));
  always #50 core_clk_in = ~core_clk_in;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [19:0] d);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_wdata_in <= d;
    sw_wr_in <= 1'b1;
    @(posedge core_clk_in);
    sw_wr_in <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [19:0] d);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_rd_in <= 1'b1;
    @(posedge core_clk_in);
    sw_rd_in <= 1'b0;
    #1 d = sw_rdata_out;
  endtask
  task automatic order(input logic [3:0] a, input logic [19:0] d, input logic [2:0] st);
    logic [19:0] v;
    sw_write(a, d);
    for (int i = 0; i < 20; i++) begin
      sw_read(rfsc_pkg::HREG_BUSY, v);
      if (v === 20'h00000) break;
    end
    check("busy", v, 20'h00000);
    sw_read(rfsc_pkg::HREG_IRQ_STATUS, v);
    check("irq_status", v, st);
  endtask
  task automatic check_ctrl(input logic [15:0] w);
    check("ref_sel", ref_sel_crystal_out, w[15]);
    check("test", test_mode_out, {w[14], w[6]});
    check("tol", lock_tol4_out, {w[13], w[5]});
    check("sign", cp_negative_out, {w[12], w[4]});
    check("gain", cp_high_gain_out, {w[11], w[3]});
    check("tx", tx_enable_out, {w[10:9] == 2'h1, w[2:1] == 2'h1});
    check("rx", rx_enable_out, {w[10:9] == 2'h2, w[2:1] == 2'h2});
    check("ps", power_save_active_low_out, {w[8], w[0]});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ctrl();
    logic [15:0] words [3] = '{16'hFBFD, 16'h0402, 16'h8000};
    logic [15:0] bad [2] = '{16'h0006, 16'h0600};
    foreach (words[i]) begin
      order(rfsc_pkg::HREG_CTRL, {4'h0, words[i]}, 3'h1);
      check_ctrl(words[i]);
    end
    foreach (bad[i]) begin
      order(rfsc_pkg::HREG_CTRL, {4'h0, bad[i]}, 3'h2);
      check_ctrl(16'h8000);
    end
  endtask
  task automatic t_div();
    order(rfsc_pkg::HREG_RX_N, 20'h00440, 3'h1);
    check("rx_n", rx_n_div_out, 20'h00440);
    order(rfsc_pkg::HREG_RX_R, 20'h00002, 3'h1);
    check("rx_r", rx_r_div_out, 13'h0002);
    order(rfsc_pkg::HREG_RX_R, 20'h01FFF, 3'h1);
    check("rx_r", rx_r_div_out, 13'h1FFF);
    order(rfsc_pkg::HREG_TX_R, 20'h01FFF, 3'h1);
    check("tx_r", tx_r_div_out, 13'h1FFF);
    order(rfsc_pkg::HREG_RX_N, 20'hFFFFF, 3'h1);
    check("rx_n", rx_n_div_out, 20'hFFFFF);
    order(rfsc_pkg::HREG_RX_N, 20'h0043F, 3'h2);
    check("rx_n", rx_n_div_out, 20'hFFFFF);
    order(rfsc_pkg::HREG_RX_R, 20'h00001, 3'h2);
    check("rx_r", rx_r_div_out, 13'h1FFF);
    order(rfsc_pkg::HREG_TX_R, 20'h02000, 3'h2);
    check("tx_r", tx_r_div_out, 13'h1FFF);
  endtask
  task automatic t_irq();
    logic [19:0] v;
    sw_write(rfsc_pkg::HREG_CTRL, 20'h00101);
    repeat (4) @(posedge core_clk_in);
    #1 check("irq_masked", irq_out, 1'b0);
    sw_write(rfsc_pkg::HREG_IRQ_MASK, 20'h00007);
    #1 check("irq_on", irq_out, 1'b1);
    sw_read(rfsc_pkg::HREG_IRQ_STATUS, v);
    check("irq_status", v, 20'h00001);
    check("irq_off", irq_out, 1'b0);
    sw_read(4'hF, v);
    check("unmapped", v, 20'h00000);
  endtask
  task automatic t_lock();
    logic [19:0] v;
    logic [1:0] lk [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    foreach (lk[i]) begin
      @(posedge core_clk_in);
      lock_in <= lk[i];
      repeat (4) @(posedge core_clk_in);
      #1 check("lock_change", lock_change_out, 1'b1);
      order(rfsc_pkg::HREG_LOCK_REQ, 20'h00000, 3'h5);
      check("lock_clear", lock_change_out, 1'b0);
      sw_read(rfsc_pkg::HREG_LOCK, v);
      check("lock_value", v, lk[i]);
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    #1 check_ctrl(16'h0000);
    t_ctrl();
    t_div();
    t_irq();
    t_lock();
    final_report();
  end
  initial begin
    #500000;
    n_mismatch++;
    final_report();
  end
endmodule
